/* src/cfe_serial_regs.sv */
`timescale 1ns/1ns
`include "cfe_defines.svh"
// How it works
// - bandwidth code 00..11 picks 20/10/5/1 MHz
// - clear: zeros, offset mid-scale 0x080
// - serial bits taken on serial clock rise
// - read data shifted out while frame low
// - six-bit gain code, 64 exponential steps
// - offset code linear, mid-scale means zero
// - delay top bits pick clock line
// - delay low bits pick one of eight steps
// - no-delay selection forces steps to zero
// - sample appears nine main clocks later
// - twelve-bit frame: flag, select, nine data
// - clear input restores all defaults
module cfe_serial_regs #(
  parameter int SAMPLE_W = `CFE_SAMPLE_W, // converted sample width
  parameter int LATENCY = `CFE_LATENCY // main clock edges of pipeline delay
) (
  input wire logic clock_i, // 250 MHz system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic serial_clk_i, // serial link clock pin
  input wire logic serial_in_i, // serial data in pin
  input wire logic frame_select_n_i, // frame select, active low
  input wire logic register_clear_n_i, // register clear, active low
  input wire logic main_sample_clock_i, // main sampling clock pin
  input wire logic [SAMPLE_W-1:0] adc_sample_i, // converted sample from core
  output logic serial_out_o, // serial data out pin
  output logic [1:0] bandwidth_sel_o, // input bandwidth code
  output logic [8:0] offset_code_o, // black-level offset code
  output logic [5:0] gain_code_o, // amplifier gain code
  output logic [2:0] delay_ref_step_o, // reference sample clock delay step
  output logic [2:0] delay_level_step_o, // level sample clock delay step
  output logic [2:0] delay_main_step_o, // main sample clock delay step
  output logic [SAMPLE_W-1:0] sample_data_o // delayed sample
);
  // refuse shapes the pipeline cannot serve
  generate
    if (LATENCY < 2 || SAMPLE_W < 1) begin : g_bad_param
      $error("cfe_serial_regs: LATENCY must be >= 2 and SAMPLE_W >= 1");
    end
  endgenerate

  localparam cfe_pkg::cfe_link_t LINK_RST = '{sclk: 1'b0, din: 1'b0, fsel_n: 1'b1,
    clear_n: 1'b1, mclk: 1'b0};
  localparam cfe_pkg::cfe_regs_t REGS_RST = '{bw: `CFE_BW_RST, off: `CFE_OFF_RST,
    gain: `CFE_GAIN_RST, dly: `CFE_DLY_RST};

  // delay step for one line, zero unless that line is selected
  function automatic logic [2:0] dly_step(input logic [4:0] dly, input logic [1:0] line);
    dly_step = (dly[4:3] == line) ? dly[2:0] : 3'h0;
  endfunction

  // register contents for a read, zero-extended to nine bits
  function automatic logic [8:0] reg_read(input cfe_pkg::cfe_regs_t r, input logic [1:0] a);
    case (a)
      `CFE_ADDR_BW: reg_read = {7'h00, r.bw};
      `CFE_ADDR_OFF: reg_read = r.off;
      `CFE_ADDR_GAIN: reg_read = {3'h0, r.gain};
      default: reg_read = {4'h0, r.dly};
    endcase
  endfunction

  logic rst_q1_r; // reset release stage one
  logic rst_q2_r; // reset release stage two, used by all logic
  cfe_pkg::cfe_link_t link_q1_r; // pin sync stage one
  cfe_pkg::cfe_link_t link_q2_r; // pin sync stage two
  logic [SAMPLE_W-1:0] samp_q1_r; // sample sync stage one
  logic [SAMPLE_W-1:0] samp_q2_r; // sample sync stage two
  logic sclk_d_r; // previous synced serial clock
  logic mclk_d_r; // previous synced main clock
  logic srise; // serial clock rising edge
  logic mrise; // main clock rising edge

  // reset release
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end

  // two-flop synchronisers and edge history
  always_ff @(posedge clock_i or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      link_q1_r <= LINK_RST;
      link_q2_r <= LINK_RST;
      samp_q1_r <= '0;
      samp_q2_r <= '0;
      sclk_d_r <= 1'b0;
      mclk_d_r <= 1'b0;
    end else begin
      link_q1_r <= '{sclk: serial_clk_i, din: serial_in_i, fsel_n: frame_select_n_i,
        clear_n: register_clear_n_i, mclk: main_sample_clock_i};
      link_q2_r <= link_q1_r;
      samp_q1_r <= adc_sample_i;
      samp_q2_r <= samp_q1_r;
      sclk_d_r <= link_q2_r.sclk;
      mclk_d_r <= link_q2_r.mclk;
    end
  end

  assign srise = link_q2_r.sclk & ~sclk_d_r;
  assign mrise = link_q2_r.mclk & ~mclk_d_r;

  // serial receiver and register bank state
  cfe_pkg::cfe_state_t st_r, st_nxt; // receiver state
  logic [3:0] cnt_r, cnt_nxt; // bits taken this frame
  logic [10:0] sh_r, sh_nxt; // bits taken so far
  logic [8:0] rd_sh_r, rd_sh_nxt; // read data being shifted out
  logic rd_act_r, rd_act_nxt; // read data shifting active
  logic sout_r, sout_nxt; // serial out level
  cfe_pkg::cfe_regs_t regs_r, regs_nxt; // configuration registers
  logic [11:0] wframe; // whole frame at the last edge
  logic wr_go; // write frame completes this cycle
  logic rd_load; // read header completes this cycle

  assign wframe = {sh_r, link_q2_r.din};

  // next-state for receiver, read shifter and registers
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rd_sh_nxt = rd_sh_r;
    rd_act_nxt = rd_act_r;
    sout_nxt = sout_r;
    regs_nxt = regs_r;
    wr_go = 1'b0;
    rd_load = 1'b0;
    case (st_r)
      cfe_pkg::cfe_idle, cfe_pkg::cfe_shift: begin
        if (link_q2_r.fsel_n) begin // frame ended early, drop it
          st_nxt = cfe_pkg::cfe_idle;
          cnt_nxt = 4'h0;
          rd_act_nxt = 1'b0;
          sout_nxt = 1'b0;
        end else if (srise) begin // take one bit
          sh_nxt = wframe[10:0];
          cnt_nxt = cnt_r + 4'h1;
          st_nxt = cfe_pkg::cfe_shift;
          if (rd_act_r) begin // next read bit, msb first
            sout_nxt = rd_sh_r[8];
            rd_sh_nxt = {rd_sh_r[7:0], 1'b0};
          end
          if (cnt_r == `CFE_HDR_LAST && sh_r[1]) begin // read header in
            rd_load = 1'b1;
            rd_act_nxt = 1'b1;
            rd_sh_nxt = reg_read(regs_r, {sh_r[0], link_q2_r.din});
          end
          if (cnt_r == `CFE_LAST_BIT) begin // twelfth bit
            st_nxt = cfe_pkg::cfe_done;
            wr_go = ~wframe[11];
          end
        end
      end
      cfe_pkg::cfe_done: begin // wait for frame select to rise
        if (link_q2_r.fsel_n) begin
          st_nxt = cfe_pkg::cfe_idle;
          cnt_nxt = 4'h0;
          rd_act_nxt = 1'b0;
          sout_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = cfe_pkg::cfe_idle;
        cnt_nxt = 4'h0;
      end
    endcase
    if (wr_go) begin // unused upper data bits ignored
      case (wframe[10:9])
        `CFE_ADDR_BW: regs_nxt.bw = wframe[1:0];
        `CFE_ADDR_OFF: regs_nxt.off = wframe[8:0];
        `CFE_ADDR_GAIN: regs_nxt.gain = wframe[5:0];
        default: begin
          if (wframe[4:3] == `CFE_DSEL_NONE) begin
            regs_nxt.dly = `CFE_DLY_RST;
          end else begin
            regs_nxt.dly = wframe[4:0];
          end
        end
      endcase
    end
    if (!link_q2_r.clear_n) begin // clear wins over a write
      regs_nxt = REGS_RST;
    end
  end

  // register receiver and bank
  always_ff @(posedge clock_i or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      st_r <= cfe_pkg::cfe_idle;
      cnt_r <= 4'h0;
      sh_r <= 11'h000;
      rd_sh_r <= 9'h000;
      rd_act_r <= 1'b0;
      sout_r <= 1'b0;
      regs_r <= REGS_RST;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rd_sh_r <= rd_sh_nxt;
      rd_act_r <= rd_act_nxt;
      sout_r <= sout_nxt;
      regs_r <= regs_nxt;
    end
  end

  assign serial_out_o = sout_r;
  assign bandwidth_sel_o = regs_r.bw;
  assign offset_code_o = regs_r.off;
  assign gain_code_o = regs_r.gain;

  // sample pipeline state
  logic [SAMPLE_W-1:0] pipe_r [LATENCY]; // samples in flight
  logic [SAMPLE_W-1:0] pipe_nxt [LATENCY];
  logic [SAMPLE_W-1:0] samp_nxt; // next output sample
  logic [2:0] dref_nxt, dlvl_nxt, dmain_nxt; // next decoded delay steps

  // advance pipeline on each main clock rise, decode delay steps
  always_comb begin
    samp_nxt = sample_data_o;
    dref_nxt = dly_step(regs_r.dly, `CFE_DSEL_REF);
    dlvl_nxt = dly_step(regs_r.dly, `CFE_DSEL_LVL);
    dmain_nxt = dly_step(regs_r.dly, `CFE_DSEL_MAIN);
    for (int i = 0; i < LATENCY; i++) begin
      pipe_nxt[i] = pipe_r[i];
    end
    if (mrise) begin
      pipe_nxt[0] = samp_q2_r;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_nxt[i] = pipe_r[i-1];
      end
      samp_nxt = pipe_r[LATENCY-1];
    end
  end

  // register pipeline and decoded delay steps
  always_ff @(posedge clock_i or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_r[i] <= '0;
      end
      sample_data_o <= '0;
      delay_ref_step_o <= 3'h0;
      delay_level_step_o <= 3'h0;
      delay_main_step_o <= 3'h0;
    end else begin
      pipe_r <= pipe_nxt;
      sample_data_o <= samp_nxt;
      delay_ref_step_o <= dref_nxt;
      delay_level_step_o <= dlvl_nxt;
      delay_main_step_o <= dmain_nxt;
    end
  end

  // checks
  AST_CLEAR_DEFAULTS: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    !link_q2_r.clear_n |=> regs_r == REGS_RST)
    else $error("clear did not restore defaults");
  AST_NODELAY_STEPS: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    regs_r.dly[4:3] == `CFE_DSEL_NONE |-> regs_r.dly[2:0] == 3'h0)
    else $error("delay steps set with no line selected");
  AST_SOUT_IDLE: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    link_q2_r.fsel_n |=> !serial_out_o) else $error("serial out active outside a frame");
  AST_GAIN_WRITE: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    wr_go && wframe[10:9] == `CFE_ADDR_GAIN && link_q2_r.clear_n |=>
    gain_code_o == $past(wframe[5:0])) else $error("gain write not stored");
  AST_REGS_STABLE: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    !wr_go && link_q2_r.clear_n |=> $stable(regs_r))
    else $error("registers changed without write");
  AST_RD_LOAD_BW: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    rd_load && {sh_r[0], link_q2_r.din} == `CFE_ADDR_BW |=>
    rd_sh_r == {7'h00, $past(regs_r.bw)})
    else $error("bandwidth read data wrong");
  AST_DLY_MAIN: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    delay_main_step_o != 3'h0 |-> $past(regs_r.dly[4:3]) == `CFE_DSEL_MAIN)
    else $error("main clock delay without main selection");
  AST_SHIFT_OUT: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    st_r != cfe_pkg::cfe_done && !link_q2_r.fsel_n && srise && rd_act_r |=>
    serial_out_o == $past(rd_sh_r[8])) else $error("read bit not presented");
  AST_FRAME_END: assert property (@(posedge clock_i) disable iff (!rst_q2_r)
    st_r == cfe_pkg::cfe_shift && !link_q2_r.fsel_n && srise && cnt_r == `CFE_LAST_BIT |=>
    st_r == cfe_pkg::cfe_done ##1 (st_r == cfe_pkg::cfe_done || link_q2_r.fsel_n))
    else $error("frame did not end after twelve bits");
endmodule

/* src/cfe_defines.svh */
`ifndef CFE_DEFINES_SVH
`define CFE_DEFINES_SVH
// serial frame layout
`define CFE_LAST_BIT 4'hb
`define CFE_HDR_LAST 4'h2
// register select codes
`define CFE_ADDR_BW 2'h0
`define CFE_ADDR_OFF 2'h1
`define CFE_ADDR_GAIN 2'h2
`define CFE_ADDR_DLY 2'h3
// register defaults after clear
`define CFE_BW_RST 2'h0
`define CFE_OFF_RST 9'h080
`define CFE_GAIN_RST 6'h00
`define CFE_DLY_RST 5'h00
// delay line selection codes
`define CFE_DSEL_NONE 2'h0
`define CFE_DSEL_REF 2'h1
`define CFE_DSEL_LVL 2'h2
`define CFE_DSEL_MAIN 2'h3
// sample path
`define CFE_LATENCY 9
`define CFE_SAMPLE_W 14
`endif

/* src/cfe_pkg.sv */
package cfe_pkg;
  // serial receiver states, one-hot
  typedef enum logic [2:0] {
    cfe_idle = 3'b001,
    cfe_shift = 3'b010,
    cfe_done = 3'b100
  } cfe_state_t;
  // the four configuration registers
  typedef struct packed {
    logic [1:0] bw;
    logic [8:0] off;
    logic [5:0] gain;
    logic [4:0] dly;
  } cfe_regs_t;
  // single-bit pins from outside the clock domain
  typedef struct packed {
    logic sclk;
    logic din;
    logic fsel_n;
    logic clear_n;
    logic mclk;
  } cfe_link_t;
endpackage

/* bench/cfe_host_model.sv */
`timescale 1ns/1ns
// host controller on the far side of the serial link
module cfe_host_model (
  input wire logic clock_i, // system clock, paces the link
  input wire logic serial_out_i, // read data from the device
  output logic serial_clk_o, // serial clock, still between frames
  output logic serial_in_o, // serial data to the device
  output logic frame_select_n_o, // frame select, active low
  output logic [2:0] power_rate_select_o // power rate pins, fixed for the sample rate
);
  // idle link: clock low, frame deselected
  initial begin
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
    frame_select_n_o = 1'b1;
    power_rate_select_o = 3'h2; // bench main clock runs above 5 MSPS
  end
  // one frame, msb first; short frames stop early, long ones add spare rises
  task automatic frame(input logic [11:0] word, input int nbits, output logic [8:0] rd);
    rd = 9'h000;
    @(negedge clock_i);
    frame_select_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_in_o = (i < 12) ? word[11 - i] : ~word[0];
      repeat (4) @(negedge clock_i);
      // read bit of the previous rise, just before the next rise
      if (i >= 4 && i < 12) rd = {rd[7:0], serial_out_i};
      serial_clk_o = 1'b1;
      repeat (4) @(negedge clock_i);
      serial_clk_o = 1'b0;
    end
    repeat (4) @(negedge clock_i);
    if (nbits >= 12) rd = {rd[7:0], serial_out_i};
    // released data line shows the inverse, never a stale copy
    serial_in_o = ~serial_in_o;
    frame_select_n_o = 1'b1;
    repeat (10) @(negedge clock_i);
  endtask
endmodule

/* bench/cfe_serial_regs_tb.sv */
`timescale 1ns/1ns
// self-checking bench for the serial register bank
module cfe_serial_regs_tb;
  logic clock_i, rst_n_i, clear_n, mclk, sclk, ser_in, fsel_n, ser_out; // pins
  logic [13:0] adc, smp_o; // sample path
  logic [1:0] bw; // bandwidth code
  logic [8:0] off, rd; // offset code, last read data
  logic [5:0] gain; // gain code
  logic [2:0] dref, dlvl, dmain; // delay steps
  int err_count = 0;
  int n_checks = 0;
  cfe_serial_regs DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .serial_clk_i(sclk),
    .serial_in_i(ser_in), .frame_select_n_i(fsel_n), .register_clear_n_i(clear_n),
    .main_sample_clock_i(mclk), .adc_sample_i(adc), .serial_out_o(ser_out),
    .bandwidth_sel_o(bw), .offset_code_o(off), .gain_code_o(gain),
    .delay_ref_step_o(dref), .delay_level_step_o(dlvl), .delay_main_step_o(dmain),
    .sample_data_o(smp_o));
  cfe_host_model host (.clock_i(clock_i), .serial_out_i(ser_out), .serial_clk_o(sclk),
    .serial_in_o(ser_in), .frame_select_n_o(fsel_n), .power_rate_select_o());
  // 4 ns system clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // all register outputs and the idle data line at once
  task automatic outs(input logic [26:0] exp);
    check(32'({bw, off, gain, dref, dlvl, dmain, ser_out}), 32'(exp));
  endtask
  task automatic wr(input logic [1:0] sel, input logic [8:0] d);
    host.frame({1'b0, sel, d}, 12, rd);
  endtask
  // read back; the low nine request bits carry junk
  task automatic rdchk(input logic [1:0] sel, input logic [8:0] exp);
    host.frame({1'b1, sel, 9'h15a}, 12, rd);
    check(32'(rd), 32'(exp));
  endtask
  task automatic t_reset();
    outs({2'h0, 9'h080, 6'h00, 9'h000, 1'b0});
    for (int s = 0; s < 4; s++) rdchk(2'(s), (s == 1) ? 9'h080 : 9'h000);
    $display("reset defaults test done");
  endtask
  // every code, with junk above the register width
  task automatic t_bw();
    for (int c = 0; c < 4; c++) begin
      wr(2'h0, {7'h55, 2'(c)});
      check(32'(bw), 32'(c));
      rdchk(2'h0, 9'(c));
    end
    $display("bandwidth test done");
  endtask
  task automatic t_gain_off();
    wr(2'h2, 9'h1ff);
    check(32'(gain), 32'h3f);
    rdchk(2'h2, 9'h03f);
    wr(2'h1, 9'h000);
    check(32'(off), 32'h0);
    wr(2'h1, 9'h1ff);
    rdchk(2'h1, 9'h1ff);
    check(32'({bw, gain}), 32'({2'h3, 6'h3f}));
    $display("gain and offset test done");
  endtask
  // each line selection, don't-care bits set
  task automatic t_delay();
    for (int s = 0; s < 4; s++) begin
      wr(2'h3, {4'hf, 2'(s), 3'h5});
      check(32'({dref, dlvl, dmain}), 32'({(s == 1) ? 3'h5 : 3'h0,
        (s == 2) ? 3'h5 : 3'h0, (s == 3) ? 3'h5 : 3'h0}));
      rdchk(2'h3, (s == 0) ? 9'h000 : {4'h0, 2'(s), 3'h5});
    end
    $display("delay test done");
  endtask
  // short frame dropped, spare rises ignored
  task automatic t_frames();
    wr(2'h2, 9'h015);
    host.frame({3'b010, 9'h02a}, 7, rd);
    check(32'(gain), 32'h15);
    host.frame({3'b010, 9'h02a}, 14, rd);
    check(32'(gain), 32'h2a);
    rdchk(2'h2, 9'h02a);
    $display("frame length test done");
  endtask
  // clear restores defaults and beats writes
  task automatic t_clear();
    clear_n = 1'b0;
    repeat (6) @(negedge clock_i);
    outs({2'h0, 9'h080, 6'h00, 9'h000, 1'b0});
    wr(2'h2, 9'h011);
    check(32'(gain), 32'h0);
    clear_n = 1'b1;
    repeat (4) @(negedge clock_i);
    wr(2'h2, 9'h011);
    rdchk(2'h2, 9'h011);
    $display("clear test done");
  endtask
  function automatic logic [13:0] smp(input int n);
    return 14'(n * 1237 + 5);
  endfunction
  // sample taken at a main clock rise shows after nine more rises
  task automatic t_sample();
    for (int n = 0; n < 20; n++) begin
      adc = smp(n);
      repeat (5) @(negedge clock_i);
      mclk = 1'b1;
      repeat (5) @(negedge clock_i);
      mclk = 1'b0;
      repeat (4) @(negedge clock_i);
      if (n >= 9) check(32'(smp_o), 32'(smp(n - 9)));
    end
    $display("sample latency test done");
  endtask
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    clear_n = 1'b1;
    mclk = 1'b0;
    adc = 14'h0000;
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge clock_i);
    t_reset();
    t_bw();
    t_gain_off();
    t_delay();
    t_frames();
    t_clear();
    t_sample();
    give_verdict();
  end
  // watchdog: the tests need about 15 us
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule
